/* shared/eoc_consts.svh */
`ifndef EOC_CONSTS_SVH
`define EOC_CONSTS_SVH

// Register address on the special-function-register bus
`define EOC_CTRL_ADDR     8'hb1
// Reset value of the control register
`define EOC_CTRL_RESET    8'h00
// Field positions inside the control register
`define EOC_VALID_BIT     7
`define EOC_MODE_MSB      6
`define EOC_MODE_LSB      4
`define EOC_RSVD_BIT      3
`define EOC_FREQ_MSB      2
`define EOC_FREQ_LSB      0
// Peripheral clock division of the external source
`define EOC_PERIPH_DIV    8
// Cycles of steady amplitude before the crystal counts as stable
`define EOC_STABLE_CYC    8'hc8
`define EOC_STABLE_W      8

`endif

/* shared/eoc_pkg.sv */
package eoc_pkg;

  // Decoded oscillator modes
  typedef enum logic [2:0] {
    EOC_OFF,
    EOC_CMOS,
    EOC_CMOS_DIV2,
    EOC_RC_CAP,
    EOC_XTAL,
    EOC_XTAL_DIV2
  } eoc_mode_t;

  // Controls handed to the analog drive circuit
  typedef struct packed {
    logic       enable;
    logic       crystal;
    logic       div2;
    logic [2:0] freq;
  } eoc_drive_t;

  // Divider state
  typedef struct packed {
    logic [3:0] cnt;
    logic       clk;
    logic       tick;
  } eoc_div_state_t;

  // Control block state
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] freq;
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_s3;
    logic       amp_s1;
    logic       amp_s2;
    logic [7:0] stable_cnt;
    logic       valid;
    logic [7:0] rdata;
  } eoc_state_t;

  // Mode field decode
  function automatic eoc_mode_t eoc_decode(input logic [2:0] code);
    eoc_mode_t m;
    case (code)
      3'h2:    m = EOC_CMOS;
      3'h3:    m = EOC_CMOS_DIV2;
      3'h4:    m = EOC_RC_CAP;
      3'h5:    m = EOC_RC_CAP;
      3'h6:    m = EOC_XTAL;
      3'h7:    m = EOC_XTAL_DIV2;
      default: m = EOC_OFF;
    endcase
    return m;
  endfunction : eoc_decode

endpackage : eoc_pkg

/* verilog/eoc_div8.sv */
`timescale 1ns/100ps
`include "eoc_consts.svh"

module eoc_div8 #(
  parameter int DIV = `EOC_PERIPH_DIV
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // Source edge stream
  input  wire logic enable_in,
  input  wire logic edge_in,
  input  wire logic pre_div2_in,
  // Divided clock
  output logic      div_clk_out,
  output logic      div_tick_out
);

  eoc_pkg::eoc_div_state_t st;
  eoc_pkg::eoc_div_state_t next_st;
  logic [3:0]              half_m1;

  // Half period in source edges, minus one
  assign half_m1 = pre_div2_in ? 4'(DIV - 1) : 4'(DIV / 2 - 1);

  // Count synchronized source edges, toggle at each half period
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (!enable_in) begin
      next_st.cnt = 4'h0;
      next_st.clk = 1'b0;
    end else if (edge_in) begin
      if (st.cnt >= half_m1) begin
        next_st.cnt  = 4'h0;
        next_st.clk  = ~st.clk;
        next_st.tick = ~st.clk;
      end else begin
        next_st.cnt = st.cnt + 4'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign div_clk_out  = st.clk;
  assign div_tick_out = st.tick;

endmodule : eoc_div8

/* verilog/eoc_top.sv */
`timescale 1ns/100ps
`include "eoc_consts.svh"

module eoc_top #(
  parameter logic [7:0] STABLE_CYC = `EOC_STABLE_CYC
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  // Special-function-register bus
  input  wire logic [7:0]        sfr_addr_in,
  input  wire logic              sfr_wr_in,
  input  wire logic              sfr_rd_in,
  input  wire logic [7:0]        sfr_wdata_in,
  output logic      [7:0]        sfr_rdata_out,
  // Analog drive circuit
  input  wire logic              osc_clk_in,
  input  wire logic              xtal_amp_ok_in,
  output eoc_pkg::eoc_drive_t    drive_ctl_out,
  // Port pin ownership
  output logic                   osc_input_pin_claim_out,
  output logic                   osc_output_pin_claim_out,
  // Peripheral clock for timers and counter array
  output logic                   ext_div8_clk_out,
  output logic                   ext_div8_tick_out
);

  eoc_pkg::eoc_state_t st;
  eoc_pkg::eoc_state_t next_st;
  eoc_pkg::eoc_mode_t  mode_dec;
  logic                xtal_mode;
  logic                div2_mode;
  logic                drive_on;
  logic                osc_rise;
  logic                ctrl_hit;
  logic [7:0]          ctrl_view;

  // Mode decode
  always_comb begin
    mode_dec  = eoc_pkg::eoc_decode(st.mode);
    xtal_mode = (mode_dec == eoc_pkg::EOC_XTAL) ||
                (mode_dec == eoc_pkg::EOC_XTAL_DIV2);
    div2_mode = (mode_dec == eoc_pkg::EOC_XTAL_DIV2) ||
                (mode_dec == eoc_pkg::EOC_CMOS_DIV2);
    drive_on  = (mode_dec != eoc_pkg::EOC_OFF);
  end

  // Bus decode and register view
  assign ctrl_hit = (sfr_addr_in == `EOC_CTRL_ADDR);
  always_comb begin
    ctrl_view = `EOC_CTRL_RESET;
    ctrl_view[`EOC_VALID_BIT] = st.valid;
    ctrl_view[`EOC_MODE_MSB:`EOC_MODE_LSB] = st.mode;
    ctrl_view[`EOC_FREQ_MSB:`EOC_FREQ_LSB] = st.freq;
  end

  // Rising edge of the synchronized oscillator clock
  assign osc_rise = st.osc_s2 & ~st.osc_s3;

  // Next state
  always_comb begin
    next_st = st;
    // Two-flop synchronizers
    next_st.osc_s1 = osc_clk_in;
    next_st.osc_s2 = st.osc_s1;
    next_st.osc_s3 = st.osc_s2;
    next_st.amp_s1 = xtal_amp_ok_in;
    next_st.amp_s2 = st.amp_s1;
    // Register write, reserved bit and valid flag ignored
    if (sfr_wr_in && ctrl_hit) begin
      next_st.mode = sfr_wdata_in[`EOC_MODE_MSB:`EOC_MODE_LSB];
      next_st.freq = sfr_wdata_in[`EOC_FREQ_MSB:`EOC_FREQ_LSB];
    end
    // Read data, unmapped addresses return zero
    if (sfr_rd_in) begin
      next_st.rdata = ctrl_hit ? ctrl_view : 8'h00;
    end
    // Amplitude must hold steady before the crystal counts as valid
    if (!xtal_mode || !st.amp_s2) begin
      next_st.stable_cnt = 8'h00;
      next_st.valid      = 1'b0;
    end else if (st.stable_cnt >= STABLE_CYC - 8'h01) begin
      next_st.valid = 1'b1;
    end else begin
      next_st.stable_cnt = st.stable_cnt + 8'h01;
    end
    // Mode change restarts settling
    if (sfr_wr_in && ctrl_hit &&
        sfr_wdata_in[`EOC_MODE_MSB:`EOC_MODE_LSB] != st.mode) begin
      next_st.stable_cnt = 8'h00;
      next_st.valid      = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Divide the synchronized oscillator edges by eight, or by sixteen in the divide-by-two modes
  eoc_div8 #(
    .DIV          (`EOC_PERIPH_DIV)
  ) u_div8 (
    .clk_sys_in   (clk_sys_in),
    .reset_in     (reset_in),
    .enable_in    (drive_on),
    .edge_in      (osc_rise),
    .pre_div2_in  (div2_mode),
    .div_clk_out  (ext_div8_clk_out),
    .div_tick_out (ext_div8_tick_out)
  );

  // Drive controls and pin ownership
  always_comb begin
    drive_ctl_out.enable  = drive_on;
    drive_ctl_out.crystal = xtal_mode;
    drive_ctl_out.div2    = div2_mode;
    drive_ctl_out.freq    = st.freq;
    osc_input_pin_claim_out  = xtal_mode;
    osc_output_pin_claim_out = drive_on;
  end

  assign sfr_rdata_out = st.rdata;

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // Helper: count cycles between divided-clock ticks
  logic [7:0] tick_gap;
  // Saturated value marks an unknown start: after reset, off or any control register write
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !drive_on || (sfr_wr_in && ctrl_hit)) begin
      tick_gap <= 8'hff;
    end else if (ext_div8_tick_out) begin
      tick_gap <= 8'h00;
    end else if (tick_gap != 8'hff) begin
      tick_gap <= tick_gap + 8'h01;
    end
  end

  a_valid_needs_xtal: assert property (
    st.valid |-> xtal_mode && (st.amp_s2 || $past(st.amp_s2)))
    else $error("valid flag set outside crystal mode");

  a_valid_read_back: assert property (
    sfr_rd_in && ctrl_hit |=> sfr_rdata_out[`EOC_VALID_BIT] == $past(st.valid))
    else $error("read data does not show valid flag");

  a_valid_after_settle: assert property (
    xtal_mode && st.amp_s2 && st.stable_cnt == STABLE_CYC - 8'h01
    && !(sfr_wr_in && ctrl_hit) |=> st.valid)
    else $error("valid flag late after settling");

  a_tick_spacing: assert property (
    ext_div8_tick_out && !div2_mode && drive_on
    |-> tick_gap >= 8'h0f)
    else $error("divided tick faster than eight source edges");

  a_tick_is_pulse: assert property (
    ext_div8_tick_out |=> !ext_div8_tick_out)
    else $error("divided tick longer than one cycle");

  a_off_no_clock: assert property (
    !drive_on |=> !ext_div8_clk_out && !ext_div8_tick_out)
    else $error("divided clock runs while oscillator off");

  a_xtal_two_pins: assert property (
    xtal_mode |-> osc_input_pin_claim_out && osc_output_pin_claim_out)
    else $error("crystal mode does not claim both pins");

  a_other_one_pin: assert property (
    drive_on && !xtal_mode
    |-> !osc_input_pin_claim_out && osc_output_pin_claim_out)
    else $error("single-pin mode claims wrong pins");

  a_mode_decode: assert property (
    st.mode[2:1] == 2'b00 |-> !drive_ctl_out.enable && !drive_ctl_out.div2)
    else $error("off code does not disable drive");

  a_valid_drop_clear: assert property (
    !st.amp_s2 |=> !st.valid)
    else $error("valid flag stays after amplitude loss");

  a_enable_decode: assert property (
    drive_ctl_out.enable == (st.mode[2:1] != 2'b00))
    else $error("drive enable does not follow mode code");

  a_crystal_decode: assert property (
    drive_ctl_out.crystal == (st.mode[2:1] == 2'b11))
    else $error("crystal select does not follow mode code");

  a_div2_decode: assert property (
    drive_ctl_out.div2 == (st.mode[1:0] == 2'b11))
    else $error("divide by two does not follow mode code");

  a_ctrl_write: assert property (
    sfr_wr_in && ctrl_hit
    |=> {1'b0, st.mode, 1'b0, st.freq} == ($past(sfr_wdata_in) & 8'h77))
    else $error("control write did not land");

  a_tick_on_rise: assert property (
    ext_div8_tick_out |-> ext_div8_clk_out && !$past(ext_div8_clk_out))
    else $error("divided tick not on a rising edge");

  a_off_no_pins: assert property (
    !drive_on |-> !osc_input_pin_claim_out && !osc_output_pin_claim_out)
    else $error("pins claimed while oscillator off");

  c_xtal_valid: cover property (xtal_mode ##1 $rose(st.valid));
  c_div8_tick: cover property (drive_on && ext_div8_tick_out);
  c_div2_tick: cover property (div2_mode && ext_div8_tick_out);
  c_cmos_mode: cover property (mode_dec == eoc_pkg::EOC_CMOS);
  c_rc_mode: cover property (mode_dec == eoc_pkg::EOC_RC_CAP);

endmodule : eoc_top

/* tb/eoc_osc_model.sv */
`timescale 1ns/100ps
// Stand-in for the crystal or clock source on the pins
module eoc_osc_model #(
  parameter int HALF_NS = 100
) (
  // Control
  input  wire logic run_in,
  // Source outputs
  output logic      osc_out,
  output logic      amp_ok_out
);
  // Source no faster than sysclk, held low when stopped
  initial begin
    osc_out = 1'b0;
    forever begin
      #7;
      if (run_in) osc_out = ~osc_out;
      else osc_out = 1'b0;
      #(HALF_NS - 7);
    end
  end

  // Amplitude good only after a settling time
  initial amp_ok_out = 1'b0;
  always @(run_in) begin
    amp_ok_out = 1'b0;
    if (run_in) amp_ok_out <= #1000 run_in;
  end
endmodule : eoc_osc_model

/* tb/tb_top.sv */
`timescale 1ns/100ps
`include "eoc_consts.svh"
module tb_top;
  localparam logic [7:0] ADDR = `EOC_CTRL_ADDR;
  logic       clk_sys_in = 1'b0;
  logic       reset_in   = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       run = 1'b0;
  logic       rd_d = 1'b0;
  logic [7:0] rdata;
  logic       osc, amp, pin_in, pin_out, dclk, tick;
  logic [8:0] e;
  logic [2:0] f;
  logic [8:0] exp_q[$];
  eoc_pkg::eoc_drive_t drv;
  int         errors = 0;
  int         checks = 0;
  int         seed = 19;
  int         n;
  int         c;

  // System clock
  always #25 clk_sys_in = ~clk_sys_in;

  eoc_top #(.STABLE_CYC(8'h04)) dut_u (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
    .sfr_rdata_out(rdata), .osc_clk_in(osc), .xtal_amp_ok_in(amp),
    .drive_ctl_out(drv), .osc_input_pin_claim_out(pin_in),
    .osc_output_pin_claim_out(pin_out), .ext_div8_clk_out(dclk),
    .ext_div8_tick_out(tick));

  eoc_osc_model #(.HALF_NS(100)) osc_u (
    .run_in(run), .osc_out(osc), .amp_ok_out(amp));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wr_reg

  // Read pulse, expectation noted beforehand (bit 8 means unchecked)
  task automatic rd_reg(input logic [7:0] a, input logic [8:0] x);
    exp_q.push_back(x);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
  endtask : rd_reg

  // Cycles between the next two ticks, bounded
  task automatic gap(output int g);
    g = 0;
    repeat (2) begin
      g = 0;
      do begin
        @(posedge clk_sys_in);
        g++;
      end while (tick !== 1'b1 && g < 300);
      if (g >= 300) begin
        errors++;
        end_sim();
      end
    end
  endtask : gap

  // Score each read result against the oldest note
  always @(posedge clk_sys_in) begin
    rd_d <= rd;
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!e[8]) chk(rdata, e[7:0]);
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_reg(ADDR, 9'h000);
    wr_reg(8'hb2, 8'h77);
    rd_reg(8'h3c, 9'h000);
    rd_reg(ADDR, 9'h000);
    // Every mode code with a random frequency field
    for (int m = 0; m < 8; m++) begin
      f = 3'($random(seed));
      wr_reg(ADDR, {1'b1, m[2:0], 1'b1, f});
      rd_reg(ADDR, {2'b00, m[2:0], 1'b0, f});
      chk(pin_out, m[2:1] != 2'b00);
      chk(pin_in, m[2:1] == 2'b11);
      chk(drv, {m[2:1] != 2'b00, m[2:1] == 2'b11, m[1] & m[0], f});
    end
    // Crystal start-up: enable, wait, poll, confirm
    wr_reg(ADDR, 8'h67);
    run <= 1'b1;
    rd_reg(ADDR, 9'h067);
    repeat (20000) @(posedge clk_sys_in);
    for (n = 0; n < 50; n++) begin
      rd_reg(ADDR, 9'h100);
      @(posedge clk_sys_in);
      if (rdata[7] === 1'b1) break;
    end
    chk(n < 50, 1'b1);
    rd_reg(ADDR, 9'h0e7);
    run <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rd_reg(ADDR, 9'h067);
    // Divided clock spacing per mode
    run <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr_reg(ADDR, k == 0 ? 8'h20 : (k == 1 ? 8'h30 : 8'h70));
      gap(c);
      gap(c);
      chk(c >= (k == 0 ? 31 : 63) && c <= (k == 0 ? 33 : 65), 1'b1);
      chk(dclk, 1'b1);
    end
    // Off mode gives no divided clock
    wr_reg(ADDR, 8'h00);
    // Last divider update before the write may still show
    @(posedge clk_sys_in);
    n = 0;
    repeat (80) begin
      @(posedge clk_sys_in);
      if (tick !== 1'b0) n++;
    end
    chk(n[7:0], 8'h00);
    chk(dclk, 1'b0);
    end_sim();
  end
endmodule : tb_top
